// file: core/ser_status.sv
// Status event reporting: standard event, service request and two filtered groups
`timescale 1ns/1ps
module ser_status
	import ser_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Command port from message parser
	input wire logic cmd_valid,
	input wire ser_cmd_e cmd_code,
	input wire logic [15:0] cmd_data,
	output logic rsp_valid_r,
	output logic [15:0] rsp_data_r,
	// Serial poll
	input wire logic serial_poll,
	output logic [7:0] poll_data_r,
	output logic srq_r,
	// Error event pulses
	input wire logic ev_query_err,
	input wire logic ev_device_err,
	input wire logic ev_exec_err,
	input wire logic ev_cmd_err,
	// Measurement engine
	input wire logic trig_count_auto,
	input wire logic stats_en,
	input wire logic func_tot_peak,
	input wire logic meas_start,
	input wire logic meas_end,
	input wire logic block_start,
	input wire logic block_end,
	// Monitored status
	input wire logic output_avail,
	input wire logic [15:0] oper_cond,
	input wire logic [15:0] ques_cond
);

	logic [7:0] sre_r;
	logic [7:0] ese_r;
	logic [7:0] esr_r;
	logic [7:0] esr_set;
	logic esr_clr;
	logic opc_wait_r;
	logic opc_fire;
	ser_pend_e pend_st_r;
	logic block_mode;
	logic pend_go;
	logic pend_stop;
	logic [15:0] cond_r [SER_NGRP];
	logic [15:0] ptr_r [SER_NGRP];
	logic [15:0] ntr_r [SER_NGRP];
	logic [15:0] ev_r [SER_NGRP];
	logic [15:0] en_r [SER_NGRP];
	logic [15:0] cond_in [SER_NGRP];
	logic [15:0] ev_set [SER_NGRP];
	logic ev_clr [SER_NGRP];
	logic [7:0] stb;
	logic mss;
	logic mss_q_r;
	logic rqs_r;
	logic is_cls;
	logic is_preset;

	function automatic logic grp_summary(input logic [15:0] ev, input logic [15:0] en);
		grp_summary = |(ev & en);
	endfunction : grp_summary

	function automatic logic is_cmd(input logic v, input ser_cmd_e c, input ser_cmd_e want);
		is_cmd = v && (c == want);
	endfunction : is_cmd

	assign is_cls = is_cmd(cmd_valid, cmd_code, SER_CMD_CLS);
	assign is_preset = is_cmd(cmd_valid, cmd_code, SER_CMD_PRESET);

	// Enables
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sre_r <= SER_SRE_RST;
			ese_r <= SER_ESE_RST;
		end else begin
			if (is_cmd(cmd_valid, cmd_code, SER_CMD_SRE_WR))
				sre_r <= cmd_data[7:0];
			if (is_cmd(cmd_valid, cmd_code, SER_CMD_ESE_WR))
				ese_r <= cmd_data[7:0];
		end
	end

	// Pending operation tracking
	assign block_mode = trig_count_auto && stats_en && !func_tot_peak;
	assign pend_go = block_mode ? block_start : meas_start;
	assign pend_stop = block_mode ? block_end : meas_end;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pend_st_r <= SER_PEND_IDLE;
		end else begin
			case (pend_st_r)
				SER_PEND_IDLE: if (pend_go) pend_st_r <= SER_PEND_BUSY;
				SER_PEND_BUSY: if (pend_stop) pend_st_r <= SER_PEND_IDLE;
				default: pend_st_r <= SER_PEND_IDLE;
			endcase
		end
	end

	// Operation complete arming
	always_comb begin
		opc_fire = 1'b0;
		// A stop in the command's own cycle counts as the pending fall
		if (is_cmd(cmd_valid, cmd_code, SER_CMD_OPC)
			&& (pend_st_r == SER_PEND_IDLE || pend_stop))
			opc_fire = 1'b1;
		if (opc_wait_r && pend_st_r == SER_PEND_BUSY && pend_stop)
			opc_fire = 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			opc_wait_r <= 1'b0;
		end else if (is_cmd(cmd_valid, cmd_code, SER_CMD_OPC) && pend_st_r == SER_PEND_BUSY
			&& !pend_stop) begin
			opc_wait_r <= 1'b1;
		end else if (is_cls || (pend_st_r == SER_PEND_BUSY && pend_stop)) begin
			opc_wait_r <= 1'b0;
		end
	end

	// Standard event status register
	always_comb begin
		esr_set = 8'h00;
		esr_set[SER_ESR_OPC] = opc_fire;
		esr_set[SER_ESR_QYE] = ev_query_err;
		esr_set[SER_ESR_DDE] = ev_device_err;
		esr_set[SER_ESR_EXE] = ev_exec_err;
		esr_set[SER_ESR_CME] = ev_cmd_err;
	end
	assign esr_clr = is_cls || is_cmd(cmd_valid, cmd_code, SER_CMD_ESR_RD);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			esr_r <= SER_ESR_RST;
		end else begin
			// A new event in the clearing cycle survives the clear
			esr_r <= ((esr_clr ? 8'h00 : esr_r) | esr_set) & SER_ESR_MASK;
		end
	end

	// Operation and questionable groups
	// Bit 15 reserved, always reads zero
	assign cond_in[SER_GRP_OPER] = oper_cond & SER_GRP_MASK;
	assign cond_in[SER_GRP_QUES] = ques_cond & SER_GRP_MASK;
	assign ev_clr[SER_GRP_OPER] = is_cls || is_cmd(cmd_valid, cmd_code, SER_CMD_OEV_RD);
	assign ev_clr[SER_GRP_QUES] = is_cls || is_cmd(cmd_valid, cmd_code, SER_CMD_QEV_RD);

	always_comb begin
		for (int g = 0; g < SER_NGRP; g++) begin
			ev_set[g] = (cond_in[g] & ~cond_r[g] & ptr_r[g])
				| (~cond_in[g] & cond_r[g] & ntr_r[g]);
		end
	end

	always_ff @(posedge clk_sys) begin
		for (int g = 0; g < SER_NGRP; g++) begin
			if (srst) begin
				cond_r[g] <= 16'h0000;
				ev_r[g] <= 16'h0000;
			end else begin
				cond_r[g] <= cond_in[g];
				ev_r[g] <= ((ev_clr[g] ? 16'h0000 : ev_r[g]) | ev_set[g]) & SER_GRP_MASK;
			end
		end
	end

	// Filters and enables; untouched by clear-status
	always_ff @(posedge clk_sys) begin
		for (int g = 0; g < SER_NGRP; g++) begin
			if (srst || is_preset) begin
				ptr_r[g] <= SER_PTR_RST;
				ntr_r[g] <= SER_NTR_RST;
				en_r[g] <= SER_EN_RST;
			end else if (cmd_valid) begin
				if (cmd_code == (g == SER_GRP_OPER ? SER_CMD_OPTR_WR : SER_CMD_QPTR_WR))
					ptr_r[g] <= cmd_data & SER_GRP_MASK;
				if (cmd_code == (g == SER_GRP_OPER ? SER_CMD_ONTR_WR : SER_CMD_QNTR_WR))
					ntr_r[g] <= cmd_data & SER_GRP_MASK;
				if (cmd_code == (g == SER_GRP_OPER ? SER_CMD_OEN_WR : SER_CMD_QEN_WR))
					en_r[g] <= cmd_data & SER_GRP_MASK;
			end
		end
	end

	// Status byte
	always_comb begin
		stb = 8'h00;
		stb[SER_STB_QSB] = grp_summary(ev_r[SER_GRP_QUES], en_r[SER_GRP_QUES]);
		stb[SER_STB_MAV] = output_avail;
		stb[SER_STB_ESB] = |(esr_r & ese_r);
		stb[SER_STB_OSB] = grp_summary(ev_r[SER_GRP_OPER], en_r[SER_GRP_OPER]);
	end
	// Bit 6 of the enable cannot request service on its own
	assign mss = |(stb & sre_r & ~(8'h01 << SER_STB_RQS));

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			srq_r <= 1'b0;
			mss_q_r <= 1'b0;
			rqs_r <= 1'b0;
			poll_data_r <= 8'h00;
		end else begin
			srq_r <= mss;
			mss_q_r <= mss;
			if (serial_poll)
				poll_data_r <= stb | ({7'h00, rqs_r} << SER_STB_RQS);
			// A new request in the poll cycle still sets the bit
			if (mss && !mss_q_r)
				rqs_r <= 1'b1;
			else if (serial_poll)
				rqs_r <= 1'b0;
		end
	end

	// Query responses
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rsp_valid_r <= 1'b0;
			rsp_data_r <= 16'h0000;
		end else begin
			rsp_valid_r <= 1'b0;
			if (cmd_valid) begin
				rsp_valid_r <= 1'b1;
				case (cmd_code)
					SER_CMD_SRE_RD: rsp_data_r <= {8'h00, sre_r};
					SER_CMD_ESR_RD: rsp_data_r <= {8'h00, esr_r};
					SER_CMD_ESE_RD: rsp_data_r <= {8'h00, ese_r};
					SER_CMD_STB_RD: rsp_data_r <= {8'h00, stb | ({7'h00, mss} << SER_STB_RQS)};
					SER_CMD_OCOND_RD: rsp_data_r <= cond_r[SER_GRP_OPER];
					SER_CMD_OPTR_RD: rsp_data_r <= ptr_r[SER_GRP_OPER];
					SER_CMD_ONTR_RD: rsp_data_r <= ntr_r[SER_GRP_OPER];
					SER_CMD_OEV_RD: rsp_data_r <= ev_r[SER_GRP_OPER];
					SER_CMD_OEN_RD: rsp_data_r <= en_r[SER_GRP_OPER];
					SER_CMD_QCOND_RD: rsp_data_r <= cond_r[SER_GRP_QUES];
					SER_CMD_QPTR_RD: rsp_data_r <= ptr_r[SER_GRP_QUES];
					SER_CMD_QNTR_RD: rsp_data_r <= ntr_r[SER_GRP_QUES];
					SER_CMD_QEV_RD: rsp_data_r <= ev_r[SER_GRP_QUES];
					SER_CMD_QEN_RD: rsp_data_r <= en_r[SER_GRP_QUES];
					default: begin
						rsp_valid_r <= 1'b0;
					end
				endcase
			end
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	chk_srq_gated: assert property ((sre_r == 8'h00 && $past(sre_r) == 8'h00) |-> !srq_r)
		else $error("service request with zero enable");
	chk_esr_cleared: assert property ((esr_clr && esr_set == 8'h00) |=> esr_r == 8'h00)
		else $error("event status not cleared");
	chk_esr_layout: assert property (!esr_r[1] && !esr_r[6])
		else $error("reserved event bit set");
	chk_opc_idle: assert property (
		(is_cmd(cmd_valid, cmd_code, SER_CMD_OPC) && pend_st_r == SER_PEND_IDLE)
		|=> esr_r[SER_ESR_OPC])
		else $error("operation complete not set at once");
	// An older completion still unread would look like an early one
	chk_opc_deferred: assert property (
		(is_cmd(cmd_valid, cmd_code, SER_CMD_OPC) && pend_st_r == SER_PEND_BUSY
		&& !pend_stop && !esr_r[SER_ESR_OPC])
		|=> opc_wait_r && !esr_r[SER_ESR_OPC])
		else $error("operation complete set while pending");
	chk_opc_fall: assert property (
		(opc_wait_r && pend_st_r == SER_PEND_BUSY && pend_stop) |=> esr_r[SER_ESR_OPC])
		else $error("operation complete missed at pending fall");
	chk_pend_rise: assert property (
		(pend_st_r == SER_PEND_IDLE && pend_go) |=> pend_st_r == SER_PEND_BUSY)
		else $error("pending did not rise");
	chk_ev_rise: assert property (
		(cond_in[SER_GRP_OPER][4] && !cond_r[SER_GRP_OPER][4] && ptr_r[SER_GRP_OPER][4])
		|=> ev_r[SER_GRP_OPER][4])
		else $error("rising edge not captured");
	chk_ev_fall: assert property (
		(!cond_in[SER_GRP_OPER][4] && cond_r[SER_GRP_OPER][4] && ntr_r[SER_GRP_OPER][4])
		|=> ev_r[SER_GRP_OPER][4])
		else $error("falling edge not captured");
	chk_ev_sticky: assert property (!ev_clr[SER_GRP_QUES]
		|=> (ev_r[SER_GRP_QUES] & $past(ev_r[SER_GRP_QUES])) == $past(ev_r[SER_GRP_QUES]))
		else $error("event bit lost without read");
	chk_ev_cls: assert property (
		(is_cls && ev_set[SER_GRP_OPER] == 16'h0000 && ev_set[SER_GRP_QUES] == 16'h0000)
		|=> ev_r[SER_GRP_OPER] == 16'h0000 && ev_r[SER_GRP_QUES] == 16'h0000)
		else $error("event register not cleared by clear status");
	chk_filter_keep: assert property (is_cls |=> $stable(ptr_r[SER_GRP_OPER])
		&& $stable(ntr_r[SER_GRP_QUES]))
		else $error("filter changed by clear status");
	chk_preset_dflt: assert property (
		is_preset |=> ptr_r[SER_GRP_QUES] == SER_PTR_RST && ntr_r[SER_GRP_OPER] == SER_NTR_RST)
		else $error("filter not at default after preset");
	chk_preset_en: assert property (
		is_preset |=> en_r[SER_GRP_OPER] == SER_EN_RST && en_r[SER_GRP_QUES] == SER_EN_RST)
		else $error("event enable not cleared by preset");
	// First edge after reset still holds the reset value
	chk_cond_follow: assert property (
		!$past(srst) |-> cond_r[SER_GRP_QUES] == $past(cond_in[SER_GRP_QUES]))
		else $error("condition does not follow status");
	chk_poll_rqs: assert property ((serial_poll && mss_q_r) |=> !rqs_r)
		else $error("request bit not cleared by poll");

	cov_opc_deferred: cover property (opc_wait_r ##[1:20] esr_r[SER_ESR_OPC]);
	cov_srq: cover property (!srq_r ##1 srq_r);
	cov_poll: cover property (rqs_r ##1 serial_poll);
	cov_fall_event: cover property (ntr_r[SER_GRP_QUES] != 16'h0000 ##1 ev_r[SER_GRP_QUES] != 16'h0000);
	cov_block_opc: cover property (block_mode && opc_wait_r ##1 !opc_wait_r);

endmodule : ser_status

// file: core/ser_pkg.sv
// Constants, command codes and states for the status event reporting block
package ser_pkg;
	localparam int SER_GRP_W = 16;
	localparam int SER_BYTE_W = 8;
	localparam int SER_NGRP = 2;
	localparam int SER_GRP_OPER = 0;
	localparam int SER_GRP_QUES = 1;

	// Standard event bit positions
	localparam int SER_ESR_OPC = 0;
	localparam int SER_ESR_QYE = 2;
	localparam int SER_ESR_DDE = 3;
	localparam int SER_ESR_EXE = 4;
	localparam int SER_ESR_CME = 5;
	localparam int SER_ESR_PON = 7;
	localparam logic [7:0] SER_ESR_MASK = 8'hbd;
	localparam logic [7:0] SER_ESR_RST = 8'h80;

	// Status byte bit positions
	localparam int SER_STB_QSB = 3;
	localparam int SER_STB_MAV = 4;
	localparam int SER_STB_ESB = 5;
	localparam int SER_STB_RQS = 6;
	localparam int SER_STB_OSB = 7;

	// Reset and preset values
	localparam logic [7:0] SER_SRE_RST = 8'h00;
	localparam logic [7:0] SER_ESE_RST = 8'h00;
	localparam logic [15:0] SER_GRP_MASK = 16'h7fff;
	localparam logic [15:0] SER_PTR_RST = 16'h7fff;
	localparam logic [15:0] SER_NTR_RST = 16'h0000;
	localparam logic [15:0] SER_EN_RST = 16'h0000;

	typedef enum logic [4:0] {
		SER_CMD_SRE_WR = 5'h00,
		SER_CMD_SRE_RD = 5'h01,
		SER_CMD_ESR_RD = 5'h02,
		SER_CMD_ESE_WR = 5'h03,
		SER_CMD_ESE_RD = 5'h04,
		SER_CMD_CLS = 5'h05,
		SER_CMD_OPC = 5'h06,
		SER_CMD_STB_RD = 5'h07,
		SER_CMD_PRESET = 5'h08,
		SER_CMD_OCOND_RD = 5'h09,
		SER_CMD_OPTR_WR = 5'h0a,
		SER_CMD_OPTR_RD = 5'h0b,
		SER_CMD_ONTR_WR = 5'h0c,
		SER_CMD_ONTR_RD = 5'h0d,
		SER_CMD_OEV_RD = 5'h0e,
		SER_CMD_OEN_WR = 5'h0f,
		SER_CMD_OEN_RD = 5'h10,
		SER_CMD_QCOND_RD = 5'h11,
		SER_CMD_QPTR_WR = 5'h12,
		SER_CMD_QPTR_RD = 5'h13,
		SER_CMD_QNTR_WR = 5'h14,
		SER_CMD_QNTR_RD = 5'h15,
		SER_CMD_QEV_RD = 5'h16,
		SER_CMD_QEN_WR = 5'h17,
		SER_CMD_QEN_RD = 5'h18
	} ser_cmd_e;

	typedef enum logic [1:0] {
		SER_PEND_IDLE = 2'b00,
		SER_PEND_BUSY = 2'b01
	} ser_pend_e;
endpackage : ser_pkg

// file: verification/ser_host.sv
// External computer model issuing status commands and queries
`timescale 1ns/1ps
module ser_host
	import ser_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Command port
	output logic cmd_valid,
	output ser_cmd_e cmd_code,
	output logic [15:0] cmd_data,
	// Response
	input wire logic rsp_valid_r,
	input wire logic [15:0] rsp_data_r
);
	initial begin
		cmd_valid = 1'b0;
		cmd_code = SER_CMD_SRE_RD;
		cmd_data = 16'h0000;
	end

	// Two idle edges first, so earlier events have landed
	task send(input ser_cmd_e code, input logic [15:0] data);
		repeat (2) @(posedge clk_sys);
		#1;
		cmd_valid = 1'b1;
		cmd_code = code;
		cmd_data = data;
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b0;
		// Released data must not look valid
		cmd_data = ~data;
	endtask : send

	task query(input ser_cmd_e code, output logic ok, output logic [15:0] data);
		send(code, 16'h0000);
		ok = rsp_valid_r;
		data = rsp_data_r;
	endtask : query
endmodule : ser_host

// file: verification/ser_status_bench.sv
// Self-checking bench for the status event reporting block
`timescale 1ns/1ps
module ser_status_bench
	import ser_pkg::*;
();
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [8:0] pv = 9'h000;
	logic [2:0] mode = 3'b000;
	logic output_avail = 1'b0;
	logic [15:0] oper_cond = 16'h0000;
	logic [15:0] ques_cond = 16'h0000;
	logic cmd_valid, rsp_valid_r, srq_r;
	ser_cmd_e cmd_code;
	logic [15:0] cmd_data, rsp_data_r;
	logic [7:0] poll_data_r;
	int fail_count = 0;
	int total_checks = 0;
	logic [2:0] modes [4] = '{3'b000, 3'b110, 3'b111, 3'b100};

	always #4 clk_sys = ~clk_sys;

	ser_status u_ser_status (
		.clk_sys, .srst, .cmd_valid, .cmd_code, .cmd_data, .rsp_valid_r, .rsp_data_r,
		.serial_poll(pv[0]), .poll_data_r, .srq_r,
		.ev_query_err(pv[1]), .ev_device_err(pv[2]), .ev_exec_err(pv[3]),
		.ev_cmd_err(pv[4]), .trig_count_auto(mode[2]), .stats_en(mode[1]),
		.func_tot_peak(mode[0]), .meas_start(pv[5]), .meas_end(pv[6]),
		.block_start(pv[7]), .block_end(pv[8]), .output_avail, .oper_cond, .ques_cond
	);

	ser_host u_ser_host (
		.clk_sys, .cmd_valid, .cmd_code, .cmd_data, .rsp_valid_r, .rsp_data_r
	);

	task report_and_stop;
		if (fail_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	task chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask : chk16

	task rd(input ser_cmd_e code, input logic [15:0] exp);
		logic ok;
		logic [15:0] d;
		u_ser_host.query(code, ok, d);
		chk16("rsp_valid", 16'h0001, {15'h0000, ok});
		chk16(code.name(), exp, d);
	endtask : rd

	// One-cycle pulses on the selected event and poll inputs
	task pulse(input logic [8:0] m);
		@(posedge clk_sys);
		#1 pv = m;
		@(posedge clk_sys);
		#1 pv = 9'h000;
	endtask : pulse

	task lvl(input logic [15:0] oc, input logic [15:0] qc);
		@(posedge clk_sys);
		#1 oper_cond = oc;
		ques_cond = qc;
		repeat (3) @(posedge clk_sys);
	endtask : lvl

	initial begin
		#200000;
		fail_count++;
		report_and_stop();
	end

	initial begin
		logic blk;
		repeat (4) @(posedge clk_sys);
		#1 srst = 1'b0;
		rd(SER_CMD_ESR_RD, 16'h0080);
		rd(SER_CMD_ESR_RD, 16'h0000);
		rd(SER_CMD_SRE_RD, 16'h0000);
		rd(SER_CMD_ESE_RD, 16'h0000);
		rd(SER_CMD_OPTR_RD, 16'h7fff);
		rd(SER_CMD_ONTR_RD, 16'h0000);
		rd(SER_CMD_OEN_RD, 16'h0000);
		// One error class at a time, so a swapped bit shows
		for (int b = 1; b < 5; b++) begin
			pulse(9'h001 << b);
			rd(SER_CMD_ESR_RD, 16'h0002 << b);
		end
		u_ser_host.send(SER_CMD_OPC, 16'h0000);
		rd(SER_CMD_ESR_RD, 16'h0001);
		// Unused code: no answer
		u_ser_host.send(ser_cmd_e'(5'h1f), 16'h0000);
		chk16("rsp_valid", 16'h0000, {15'h0000, rsp_valid_r});
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			#1 mode = modes[i];
			blk = (modes[i] == 3'b110);
			pulse(blk ? 9'h080 : 9'h020);
			u_ser_host.send(SER_CMD_OPC, 16'h0000);
			if (blk) begin
				pulse(9'h040);
			end
			rd(SER_CMD_ESR_RD, 16'h0000);
			pulse(blk ? 9'h100 : 9'h040);
			rd(SER_CMD_ESR_RD, 16'h0001);
		end
		output_avail = 1'b1;
		u_ser_host.send(SER_CMD_ESE_WR, 16'h0004);
		u_ser_host.send(SER_CMD_SRE_WR, 16'h0020);
		rd(SER_CMD_SRE_RD, 16'h0020);
		pulse(9'h002);
		repeat (3) @(posedge clk_sys);
		#1;
		chk16("srq", 16'h0001, {15'h0000, srq_r});
		rd(SER_CMD_STB_RD, 16'h0070);
		pulse(9'h001);
		chk16("poll", 16'h0070, {8'h00, poll_data_r});
		pulse(9'h001);
		chk16("poll", 16'h0030, {8'h00, poll_data_r});
		u_ser_host.send(SER_CMD_SRE_WR, 16'h0000);
		repeat (2) @(posedge clk_sys);
		#1;
		chk16("srq", 16'h0000, {15'h0000, srq_r});
		rd(SER_CMD_ESR_RD, 16'h0004);
		rd(SER_CMD_STB_RD, 16'h0010);
		output_avail = 1'b0;
		lvl(16'h0010, 16'h0000);
		rd(SER_CMD_OCOND_RD, 16'h0010);
		rd(SER_CMD_OCOND_RD, 16'h0010);
		lvl(16'h0000, 16'h0000);
		rd(SER_CMD_OEV_RD, 16'h0010);
		rd(SER_CMD_OEV_RD, 16'h0000);
		u_ser_host.send(SER_CMD_OPTR_WR, 16'h0000);
		u_ser_host.send(SER_CMD_ONTR_WR, 16'h0010);
		u_ser_host.send(SER_CMD_OEN_WR, 16'h0010);
		lvl(16'h0010, 16'h0000);
		rd(SER_CMD_OEV_RD, 16'h0000);
		rd(SER_CMD_STB_RD, 16'h0000);
		lvl(16'h0000, 16'h0000);
		rd(SER_CMD_STB_RD, 16'h0080);
		rd(SER_CMD_OEV_RD, 16'h0010);
		u_ser_host.send(SER_CMD_QEN_WR, 16'h0004);
		lvl(16'h0000, 16'h0004);
		rd(SER_CMD_STB_RD, 16'h0008);
		u_ser_host.send(SER_CMD_CLS, 16'h0000);
		rd(SER_CMD_QEV_RD, 16'h0000);
		rd(SER_CMD_STB_RD, 16'h0000);
		rd(SER_CMD_ONTR_RD, 16'h0010);
		rd(SER_CMD_QEN_RD, 16'h0004);
		u_ser_host.send(SER_CMD_PRESET, 16'h0000);
		rd(SER_CMD_ONTR_RD, 16'h0000);
		rd(SER_CMD_OPTR_RD, 16'h7fff);
		rd(SER_CMD_QEN_RD, 16'h0000);
		u_ser_host.send(SER_CMD_QNTR_WR, 16'h0004);
		u_ser_host.send(SER_CMD_ESE_WR, 16'h0020);
		// Second power-on in mid-run
		@(posedge clk_sys);
		#1 srst = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1 srst = 1'b0;
		rd(SER_CMD_ESR_RD, 16'h0080);
		rd(SER_CMD_ESE_RD, 16'h0000);
		rd(SER_CMD_QNTR_RD, 16'h0000);
		report_and_stop();
	end
endmodule : ser_status_bench
